// ### core/spl_pkg.sv
// Purpose: Shared constants and types for the safety output test pulse block
// Assumes: 100 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package spl_pkg;

	localparam int NUM_TEST  = 8;
	localparam int NUM_SAFE  = 8;
	localparam int NUM_SIN   = 8;
	localparam int NUM_LATCH = NUM_TEST + NUM_SAFE + NUM_SIN;

	localparam int CNT_W = 17;
	localparam int MS_W  = 16;
	localparam int LT_W  = 13;

	localparam logic [3:0] ADDR_TMODE = 4'h0;
	localparam logic [3:0] ADDR_SMODE = 4'h1;
	localparam logic [3:0] ADDR_DUAL  = 4'h2;
	localparam logic [3:0] ADDR_LATCH = 4'h3;
	localparam logic [3:0] ADDR_ERR   = 4'h4;
	localparam logic [3:0] ADDR_VIOL  = 4'h5;
	localparam logic [3:0] ADDR_HIST  = 4'h6;

	localparam int ERR_TEST_LSB = 0;
	localparam int ERR_SAFE_LSB = 8;
	localparam int ERR_SIN_LSB  = 16;
	localparam int HIST_CNT_LSB = 0;
	localparam int HIST_SRC_LSB = 16;

	localparam logic [7:0] MUTE_OK_SMALL = 8'h08;
	localparam logic [7:0] MUTE_OK_LARGE = 8'h88;

	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int OFF_PULSE_NS  = 580000;
	localparam int TEST_PULSE_NS = 500000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int OFF_PULSE_CYC =
		(OFF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TEST_PULSE_CYC =
		(TEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int LATCH_STEP_MS    = 10;
	localparam int LATCH_DEFAULT_MS = 1000;
	localparam logic [LT_W-1:0] LATCH_RST =
		LT_W'(LATCH_DEFAULT_MS / LATCH_STEP_MS);

	typedef enum logic [1:0] {TM_UNUSED, TM_STD, TM_PULSE, TM_MUTE}
		spl_tmode_t;
	typedef enum logic [1:0] {SM_UNUSED, SM_SAFE, SM_PULSE} spl_smode_t;

endpackage

// ### core/spl_latch_if.sv
// Purpose: Carries one terminal's error latch request and state
// Assumes: Single clock domain
// Notes:   ctrl side is the main controller, unit side the latch
`timescale 1ns/1ps
`default_nettype none
interface spl_latch_if;
	import spl_pkg::*;
	logic            tick;
	logic            fault;
	logic            clr_ok;
	logic [MS_W-1:0] reload_ms;
	logic            err;
	modport ctrl (output tick, fault, clr_ok, reload_ms, input err);
	modport unit (input tick, fault, clr_ok, reload_ms, output err);
endinterface
`default_nettype wire

// ### core/spl_err_latch.sv
// Purpose: Per-terminal error latch with millisecond down-counter
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   First millisecond may be short by up to one tick period
`timescale 1ns/1ps
`default_nettype none
module spl_err_latch
	import spl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	spl_latch_if.unit lp
);

	logic [MS_W-1:0] cnt_reg;
	logic            err_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
		end else if (lp.fault) begin
			cnt_reg <= lp.reload_ms;
		end else if (lp.tick && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// A fault in the clearing cycle wins, so no event is lost
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_reg <= 1'b0;
		end else if (lp.fault) begin
			err_reg <= 1'b1;
		end else if (cnt_reg == '0 && lp.clr_ok) begin
			err_reg <= 1'b0;
		end
	end

	assign lp.err = err_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_latch_reload: assert property (
		lp.fault |=> (err_reg && cnt_reg == $past(lp.reload_ms)))
		else $error("latch not reloaded on fault");
	a_latch_holds: assert property (
		(err_reg && cnt_reg != '0) |=> err_reg)
		else $error("error dropped before latch time");
	a_latch_clears: assert property (
		(err_reg && !lp.fault && cnt_reg == '0 && lp.clr_ok) |=> !err_reg)
		else $error("error not cleared when allowed");

endmodule
`default_nettype wire

// ### core/spl_ctrl.sv
// Purpose: Test output and safety output terminal control with diagnostics
// Assumes: Tags and feedback inputs synchronous to clk_i
// Notes:   Feedback inputs carry the sensed pin levels; lamp_ok_i the
//          lamp current sense of a muting lamp terminal
//
// Summary of operation
// - Input error clears: cause gone, time, inactive
// - Four test terminals small, eight large
// - Test modes unused/standard/pulse/lamp; unused undriven
// - Test pulses staggered, never two together
// - Lamp mode detects open lamp while on
// - Lamp mode only on terminal four or eight
// - Faulty test terminal forced inactive
// - Errors logged, all else runs except the partner of a dual pair
// - Error held for latch time, 10 ms steps
// - Test terminal error clears after latch time
// - Eight safety outputs; supply short, ground checks
// - Plain safety mode: no pulse while on
// - Pulse mode pulses output while on
// - Pulse mode turn-on inserts 580 us off pulse
// - Dual mismatch of tags flags an error
// - Error on either pair output stops both
// - Pair turns on only if both fault-free
// - Single channel: terminal follows its tag
// - Even-based pairs; mismatch forces both off
// - Unused safety output left undriven
// - Output error clears: cause, time, tags off
`timescale 1ns/1ps
`default_nettype none
module spl_ctrl
	import spl_pkg::*;
#(
	parameter int unsigned TICK_CYCLES       = MS_CYCLES,
	parameter int unsigned OFF_PULSE_CYCLES  = OFF_PULSE_CYC,
	parameter int unsigned TEST_PULSE_CYCLES = TEST_PULSE_CYC,
	parameter bit          LARGE_VARIANT     = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic [7:0]  test_tag_i,
	input  wire logic [7:0]  test_fb_i,
	input  wire logic [7:0]  lamp_ok_i,
	output logic      [7:0]  test_o,
	output logic      [7:0]  test_oe_o,
	input  wire logic [7:0]  safe_tag_i,
	input  wire logic [7:0]  safe_fb_i,
	output logic      [7:0]  safe_o,
	output logic      [7:0]  safe_oe_o,
	input  wire logic [7:0]  sin_fault_i,
	input  wire logic [7:0]  sin_active_i,
	output logic      [7:0]  test_err_o,
	output logic      [7:0]  safe_err_o,
	output logic      [7:0]  sin_err_o,
	output logic      [3:0]  violation_o
);

	localparam logic [7:0] MUTE_OK = LARGE_VARIANT ? MUTE_OK_LARGE
		: MUTE_OK_SMALL;
	localparam int N_TEST_USED = LARGE_VARIANT ? NUM_TEST : 4;

	logic rst_s1_reg;
	logic rst_n_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// Mode legality; small variant terminals above four stay unused
	function automatic logic tmode_ok(input int idx, input logic [1:0] m);
		logic ok;
		ok = 1'b1;
		if (idx >= N_TEST_USED) begin
			ok = (m == TM_UNUSED);
		end else if (m == TM_MUTE) begin
			ok = MUTE_OK[idx];
		end
		return ok;
	endfunction

	function automatic logic [4:0] first_set(input logic [NUM_LATCH-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_LATCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	logic [CNT_W-1:0] ms_cnt_reg;
	logic [2:0]       slot_reg;
	logic             tick;

	assign tick = (ms_cnt_reg == CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ms_cnt_reg <= '0;
			slot_reg   <= 3'h0;
		end else if (tick) begin
			ms_cnt_reg <= '0;
			slot_reg   <= slot_reg + 3'h1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 1'b1;
		end
	end

	spl_tmode_t      tmode_reg [NUM_TEST];
	spl_smode_t      smode_reg [NUM_SAFE];
	logic [3:0]      dual_reg;
	logic [LT_W-1:0] latch_reg;
	logic [MS_W-1:0] reload_ms;

	assign reload_ms = MS_W'(latch_reg * LATCH_STEP_MS);

	// Refused mode codes leave the field as it was
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < NUM_TEST; i++) begin
				tmode_reg[i] <= TM_UNUSED;
				smode_reg[i] <= SM_UNUSED;
			end
			dual_reg  <= 4'h0;
			latch_reg <= LATCH_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				ADDR_TMODE: begin
					for (int i = 0; i < NUM_TEST; i++) begin
						if (tmode_ok(i, wdata_i[2*i +: 2])) begin
							tmode_reg[i] <= spl_tmode_t'(wdata_i[2*i +: 2]);
						end
					end
				end
				ADDR_SMODE: begin
					for (int i = 0; i < NUM_SAFE; i++) begin
						if (wdata_i[2*i +: 2] != 2'h3) begin
							smode_reg[i] <= spl_smode_t'(wdata_i[2*i +: 2]);
						end
					end
				end
				ADDR_DUAL:  dual_reg  <= wdata_i[3:0];
				ADDR_LATCH: latch_reg <= wdata_i[LT_W-1:0];
				default: ;
			endcase
		end
	end

	spl_latch_if lif [NUM_LATCH] ();

	logic [NUM_LATCH-1:0] all_err;
	logic [7:0]           test_err;
	logic [7:0]           safe_err;
	logic [7:0]           tp_now;
	logic [7:0]           tunused;
	logic [7:0]           tmute;
	logic [7:0]           tq_reg;
	logic [7:0]           tpulse;

	assign test_err = all_err[7:0];
	assign safe_err = all_err[15:8];

	for (genvar g = 0; g < NUM_LATCH; g++) begin : g_latch
		assign lif[g].tick      = tick;
		assign lif[g].reload_ms = reload_ms;
		assign all_err[g]       = lif[g].err;
		spl_err_latch u_latch (
			.clk_i   (clk_i),
			.rst_n_i (rst_n_reg),
			.lp      (lif[g])
		);
	end

	for (genvar g = 0; g < NUM_TEST; g++) begin : g_test
		logic drv;
		logic fault;
		assign tunused[g] = (tmode_reg[g] == TM_UNUSED);
		assign tmute[g]   = (tmode_reg[g] == TM_MUTE);
		assign tpulse[g]  = (tmode_reg[g] == TM_PULSE);
		// One slot per terminal keeps the pulses apart
		assign tp_now[g]  = (tmode_reg[g] == TM_PULSE) && (slot_reg == 3'(g))
			&& (ms_cnt_reg < CNT_W'(TEST_PULSE_CYCLES));
		always_comb begin
			unique case (tmode_reg[g])
				TM_UNUSED: drv = 1'b0;
				TM_STD:    drv = test_tag_i[g];
				TM_PULSE:  drv = !tp_now[g];
				TM_MUTE:   drv = test_tag_i[g];
			endcase
		end
		always_ff @(posedge clk_i or negedge rst_n_reg) begin
			if (!rst_n_reg) begin
				test_o[g]    <= 1'b0;
				test_oe_o[g] <= 1'b0;
				tq_reg[g]    <= 1'b0;
			end else begin
				test_o[g]    <= drv && !test_err[g];
				test_oe_o[g] <= !tunused[g];
				tq_reg[g]    <= test_o[g];
			end
		end
		// Compare only once the level has stood for two cycles
		assign fault = test_oe_o[g] && (((test_o[g] == tq_reg[g])
			&& (test_fb_i[g] != test_o[g]))
			|| (tmute[g] && test_o[g] && !lamp_ok_i[g]));
		assign lif[g].fault  = fault;
		assign lif[g].clr_ok = 1'b1;
	end

	logic [7:0]       viol8;
	logic [7:0]       pair_err;
	logic [7:0]       cmd;
	logic [7:0]       cmd_q_reg;
	logic [7:0]       busy;
	logic [7:0]       splain;
	logic [7:0]       sq_reg;

	for (genvar g = 0; g < NUM_SAFE; g++) begin : g_safe
		logic             dual;
		logic             eff;
		logic             fault;
		logic [CNT_W-1:0] opc_reg;
		logic             rise;
		assign dual  = dual_reg[g/2];
		assign viol8[g] = dual
			&& (safe_tag_i[g] != safe_tag_i[g^1]);
		assign eff   = dual ? (safe_tag_i[g] && safe_tag_i[g^1])
			: safe_tag_i[g];
		assign pair_err[g] = safe_err[g]
			|| (dual && safe_err[g^1]);
		assign cmd[g] = (smode_reg[g] != SM_UNUSED) && eff
			&& !pair_err[g];
		assign splain[g] = (smode_reg[g] == SM_SAFE);
		assign busy[g]   = (opc_reg != '0);
		// The counter loads one edge late; hold the pin low on that edge
		assign rise = (smode_reg[g] == SM_PULSE) && cmd[g]
			&& !cmd_q_reg[g];
		// Off pulse at turn-on and again in this output's slot while on
		always_ff @(posedge clk_i or negedge rst_n_reg) begin
			if (!rst_n_reg) begin
				opc_reg <= '0;
			end else if (smode_reg[g] != SM_PULSE) begin
				opc_reg <= '0;
			end else if (opc_reg != '0) begin
				opc_reg <= opc_reg - 1'b1;
			end else if (cmd[g] && (!cmd_q_reg[g]
				|| (tick && slot_reg == 3'(g)))) begin
				opc_reg <= CNT_W'(OFF_PULSE_CYCLES);
			end
		end
		always_ff @(posedge clk_i or negedge rst_n_reg) begin
			if (!rst_n_reg) begin
				cmd_q_reg[g] <= 1'b0;
				safe_o[g]    <= 1'b0;
				safe_oe_o[g] <= 1'b0;
				sq_reg[g]    <= 1'b0;
			end else begin
				cmd_q_reg[g] <= cmd[g];
				safe_o[g]    <= cmd[g] && !busy[g] && !rise;
				safe_oe_o[g] <= (smode_reg[g] != SM_UNUSED);
				sq_reg[g]    <= safe_o[g];
			end
		end
		// Stuck high while off: supply short; stuck low while on: ground
		assign fault = safe_oe_o[g] && (safe_o[g] == sq_reg[g])
			&& (safe_fb_i[g] != safe_o[g]);
		assign lif[g+8].fault  = fault || viol8[g];
		assign lif[g+8].clr_ok = !safe_tag_i[g]
			&& !(dual && safe_tag_i[g^1]);
	end

	for (genvar g = 0; g < NUM_SIN; g++) begin : g_sin
		assign lif[g+16].fault  = sin_fault_i[g];
		assign lif[g+16].clr_ok = !sin_active_i[g];
	end

	logic [NUM_LATCH-1:0] err_q_reg;
	logic [NUM_LATCH-1:0] new_err;
	logic [15:0]          log_cnt_reg;
	logic [4:0]           last_src_reg;

	assign new_err = all_err & ~err_q_reg;

	// History only records; an error stops nothing but its own terminal and its dual pair partner
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			err_q_reg    <= '0;
			log_cnt_reg  <= 16'h0000;
			last_src_reg <= 5'h00;
		end else begin
			err_q_reg <= all_err;
			if (|new_err) begin
				last_src_reg <= first_set(new_err);
				if (log_cnt_reg != 16'hffff) begin
					log_cnt_reg <= log_cnt_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			violation_o <= 4'h0;
		end else begin
			violation_o <= {viol8[6], viol8[4], viol8[2], viol8[0]};
		end
	end

	assign test_err_o = test_err;
	assign safe_err_o = safe_err;
	assign sin_err_o  = all_err[23:16];

	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (addr_i)
			ADDR_TMODE: begin
				for (int i = 0; i < NUM_TEST; i++) begin
					rd_word[2*i +: 2] = tmode_reg[i];
				end
			end
			ADDR_SMODE: begin
				for (int i = 0; i < NUM_SAFE; i++) begin
					rd_word[2*i +: 2] = smode_reg[i];
				end
			end
			ADDR_DUAL:  rd_word[3:0] = dual_reg;
			ADDR_LATCH: rd_word[LT_W-1:0] = latch_reg;
			ADDR_ERR:   rd_word[NUM_LATCH-1:0] = all_err;
			ADDR_VIOL:  rd_word[3:0] = violation_o;
			ADDR_HIST: begin
				rd_word[HIST_CNT_LSB +: 16] = log_cnt_reg;
				rd_word[HIST_SRC_LSB +: 5]  = last_src_reg;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= rd_word;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_reg);

	a_test_unused_idle: assert property (
		1'b1 |=> (test_oe_o & $past(tunused)) == 8'h00)
		else $error("unused test terminal driven");
	a_pulse_stagger: assert property (
		$onehot0(~test_o & $past(tpulse) & ~$past(test_err)))
		else $error("two test pulses at once");
	a_mute_legal_slot: assert property (
		(tmute & ~MUTE_OK) == 8'h00)
		else $error("lamp mode on illegal terminal");
	a_test_err_off: assert property (
		1'b1 |=> (test_o & $past(test_err)) == 8'h00)
		else $error("faulty test terminal not forced off");
	a_hist_count: assert property (
		(|new_err && log_cnt_reg != 16'hffff)
		|=> log_cnt_reg == $past(log_cnt_reg) + 16'h0001)
		else $error("error not logged");
	a_dual_viol_off: assert property (
		1'b1 |=> (safe_o & $past(viol8)) == 8'h00)
		else $error("mismatched pair not forced off");
	a_dual_pair_err: assert property (
		1'b1 |=> (safe_o & $past(pair_err)) == 8'h00)
		else $error("pair output on with a pair error");
	a_off_pulse_load: assert property (
		($past(g_safe[0].opc_reg) == '0 && g_safe[0].opc_reg != '0)
		|-> g_safe[0].opc_reg == CNT_W'(OFF_PULSE_CYCLES))
		else $error("off pulse width wrong");
	a_plain_no_pulse: assert property (
		1'b1 |=> (busy & $past(splain)) == 8'h00)
		else $error("pulse in plain safety mode");

endmodule
`default_nettype wire

// ### bench/spl_ext_model.sv
// Purpose: External loads on the test and safety terminals
// Assumes: A load pulls an undriven pin to ground
// Notes:   Fault masks short a pin to ground or open the lamp
`timescale 1ns/1ps
`default_nettype none
module spl_ext_model (
	input  wire logic [7:0] test_i,
	input  wire logic [7:0] test_oe_i,
	input  wire logic [7:0] safe_i,
	input  wire logic [7:0] safe_oe_i,
	input  wire logic [7:0] test_gnd_i,
	input  wire logic [7:0] safe_gnd_i,
	input  wire logic [7:0] lamp_open_i,
	output logic      [7:0] test_fb_o,
	output logic      [7:0] safe_fb_o,
	output logic      [7:0] lamp_ok_o
);
	// No input filter here, so every short off pulse reaches the sense
	assign test_fb_o = test_i & test_oe_i & ~test_gnd_i;
	assign safe_fb_o = safe_i & safe_oe_i & ~safe_gnd_i;
	assign lamp_ok_o = ~lamp_open_i;
endmodule
`default_nettype wire

// ### bench/spl_ctrl_tb_top.sv
// Purpose: Self-checking bench for the terminal control block
// Assumes: Short tick and pulse parameters keep the run brief
// Notes:   Latch set to one step, i.e. ten ticks of TK cycles
`timescale 1ns/1ps
`default_nettype none
module spl_ctrl_tb_top;
	import spl_pkg::*;
	localparam int TK = 20;
	localparam int OP = 5;
	localparam int TP = 4;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [7:0]  test_tag_i = 8'h0;
	logic [7:0]  safe_tag_i = 8'h0;
	logic [7:0]  sin_fault_i = 8'h0;
	logic [7:0]  sin_active_i = 8'h0;
	logic [7:0]  tgnd = 8'h0;
	logic [7:0]  sgnd = 8'h0;
	logic [7:0]  lopen = 8'h0;
	logic [7:0]  test_fb_i, lamp_ok_i, test_o, test_oe_o;
	logic [7:0]  safe_fb_i, safe_o, safe_oe_o;
	logic [7:0]  test_err_o, safe_err_o, sin_err_o;
	logic [3:0]  violation_o;
	logic [23:0] errs;
	logic [31:0] seed = 32'd84743;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;
	int          lo[8];
	int          maxn;

	assign errs = {sin_err_o, safe_err_o, test_err_o};

	spl_ctrl #(.TICK_CYCLES(TK), .OFF_PULSE_CYCLES(OP),
		.TEST_PULSE_CYCLES(TP), .LARGE_VARIANT(1'b1)) u_spl_ctrl (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.test_tag_i(test_tag_i), .test_fb_i(test_fb_i),
		.lamp_ok_i(lamp_ok_i), .test_o(test_o), .test_oe_o(test_oe_o),
		.safe_tag_i(safe_tag_i), .safe_fb_i(safe_fb_i), .safe_o(safe_o),
		.safe_oe_o(safe_oe_o), .sin_fault_i(sin_fault_i),
		.sin_active_i(sin_active_i), .test_err_o(test_err_o),
		.safe_err_o(safe_err_o), .sin_err_o(sin_err_o),
		.violation_o(violation_o));

	spl_ext_model u_spl_ext_model (
		.test_i(test_o), .test_oe_i(test_oe_o), .safe_i(safe_o),
		.safe_oe_i(safe_oe_o), .test_gnd_i(tgnd), .safe_gnd_i(sgnd),
		.lamp_open_i(lopen), .test_fb_o(test_fb_i),
		.safe_fb_o(safe_fb_i), .lamp_ok_o(lamp_ok_i));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic conclude;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic wait_err(input int b, input logic v, input int lim);
		for (int k = 0; k < lim && errs[b] !== v; k++)
			cyc(1);
	endtask

	// Counts low cycles per terminal and the widest overlap of lows
	task automatic scan(input bit sf, input int len);
		logic [7:0] o;
		int         n;
		lo   = '{default: 0};
		maxn = 0;
		repeat (len) begin
			cyc(1);
			o = sf ? safe_o : test_o;
			n = 0;
			for (int i = 0; i < 8; i++) begin
				n += int'(o[i] === 1'b0);
				lo[i] += int'(o[i] === 1'b0);
			end
			if (n > maxn)
				maxn = n;
		end
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		logic [31:0] v;
		int          n;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		cyc(4);
		rd(ADDR_LATCH, v);
		check("latch reset", v, 32'(LATCH_RST));
		for (int a = 0; a < 16; a++) begin
			if (a != 3) begin
				rd(4'(a), v);
				check("reg reset", v, 32'h0);
			end
		end
		wr(ADDR_LATCH, 32'h1fff);
		rd(ADDR_LATCH, v);
		check("latch max", v, 32'h1fff);
		wr(ADDR_LATCH, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_TMODE, 32'h3 << (2 * i));
			rd(ADDR_TMODE, v);
			n = (i == 3 || i == 7) ? 32'h3 << (2 * i) : 0;
			check("lamp slot", v, n);
			wr(ADDR_TMODE, 32'h0);
		end
		// Terminals 0 and 1 stay unused while the rest follow their tags
		wr(ADDR_TMODE, 32'h5550);
		repeat (4) begin
			seed = xs(seed);
			@(posedge clk_i);
			test_tag_i <= seed[7:0];
			cyc(3);
			check("test std", test_o, seed[7:0] & 8'hfc);
			check("test oe", test_oe_o, 8'hfc);
		end
		wr(ADDR_TMODE, 32'haaaa);
		cyc(3);
		scan(1'b0, 200);
		check("stagger", maxn <= 1, 1);
		for (int i = 0; i < 8; i++)
			check("test pulse", lo[i] >= TP, 1);
		wr(ADDR_TMODE, 32'h5555);
		@(posedge clk_i);
		test_tag_i <= 8'hff;
		cyc(3);
		tgnd <= 8'h04;
		wait_err(2, 1'b1, 20);
		cyc(2);
		check("test err", test_err_o, 8'h04);
		check("test forced", test_o, 8'hfb);
		tgnd <= 8'h00;
		rd(ADDR_HIST, v);
		check("history", v, 32'h00020001);
		cyc(150);
		check("test held", test_err_o, 8'h04);
		wait_err(2, 1'b0, 120);
		check("test clear", test_err_o, 8'h00);
		wr(ADDR_TMODE, 32'hc0);
		lopen <= 8'h08;
		wait_err(3, 1'b1, 20);
		cyc(2);
		check("lamp err", test_err_o, 8'h08);
		check("lamp off", test_o[3], 1'b0);
		lopen <= 8'h00;
		rd(ADDR_HIST, v);
		check("history 2", v, 32'h00030002);
		wait_err(3, 1'b0, 260);
		check("lamp clear", test_err_o, 8'h00);
		wr(ADDR_TMODE, 32'h0);
		wr(ADDR_SMODE, 32'h5550);
		repeat (4) begin
			seed = xs(seed);
			@(posedge clk_i);
			safe_tag_i <= seed[7:0];
			cyc(3);
			check("safe single", safe_o, seed[7:0] & 8'hfc);
			check("safe oe", safe_oe_o, 8'hfc);
		end
		wr(ADDR_SMODE, 32'h5555);
		@(posedge clk_i);
		safe_tag_i <= 8'hff;
		cyc(3);
		scan(1'b1, 200);
		check("no pulse on", maxn, 0);
		@(posedge clk_i);
		safe_tag_i <= 8'h00;
		wr(ADDR_SMODE, 32'h2);
		cyc(3);
		@(posedge clk_i);
		safe_tag_i <= 8'h01;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (safe_o[0] !== 1'b1 && n < 30);
		check("turn on off", n >= OP && n <= OP + 4, 1);
		scan(1'b1, 200);
		check("pulse on", lo[0] >= OP, 1);
		@(posedge clk_i);
		safe_tag_i <= 8'h00;
		wr(ADDR_SMODE, 32'h5555);
		wr(ADDR_DUAL, 32'h1);
		@(posedge clk_i);
		safe_tag_i <= 8'h03;
		cyc(3);
		check("dual on", safe_o, 8'h03);
		@(posedge clk_i);
		safe_tag_i <= 8'h01;
		cyc(3);
		check("violation", violation_o, 4'h1);
		check("dual off", safe_o, 8'h00);
		check("dual err", safe_err_o, 8'h03);
		@(posedge clk_i);
		safe_tag_i <= 8'h03;
		cyc(260);
		check("tags hold err", safe_err_o, 8'h03);
		check("no restart", safe_o, 8'h00);
		check("viol gone", violation_o, 4'h0);
		@(posedge clk_i);
		safe_tag_i <= 8'h00;
		wait_err(8, 1'b0, 20);
		check("dual clear", safe_err_o, 8'h00);
		@(posedge clk_i);
		safe_tag_i <= 8'h03;
		cyc(4);
		sgnd <= 8'h02;
		wait_err(9, 1'b1, 20);
		cyc(2);
		check("pair stop", safe_o, 8'h00);
		sgnd <= 8'h00;
		@(posedge clk_i);
		safe_tag_i <= 8'h00;
		wait_err(9, 1'b0, 260);
		check("pair clear", safe_err_o, 8'h00);
		@(posedge clk_i);
		sin_active_i <= 8'h01;
		sin_fault_i  <= 8'h01;
		wait_err(16, 1'b1, 20);
		rd(ADDR_ERR, v);
		check("input err", v, 32'h00010000);
		@(posedge clk_i);
		sin_fault_i <= 8'h00;
		cyc(260);
		check("input held", sin_err_o, 8'h01);
		@(posedge clk_i);
		sin_active_i <= 8'h00;
		wait_err(16, 1'b0, 20);
		check("input clear", sin_err_o, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
